//--- hw/ioppf_top.sv
/*
 Pin-function logic: memory strobes, port 0/2 drive and handshake,
 port 3 routing of interrupts, timers and comparators, APB slave.
 Assumes pin inputs are asynchronous; core and timer inputs are on pclk.
*/
// Implementation choices: the APB interface to the registers and the register offsets.
`default_nettype none
module ioppf_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic mem_data_space,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_done,
  output logic cycle_address_strobe_n,
  output logic mem_transfer_strobe_n,
  output logic read_write,
  output logic strobe_oe_n,
  input wire logic [7:0] p0_in,
  output logic [7:0] p0_out,
  output logic [7:0] p0_oe_n,
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe_n,
  input wire logic [7:0] p2_in,
  output logic [7:0] p2_out,
  output logic [7:0] p2_oe_n,
  input wire logic [3:1] p3_in,
  output logic [7:4] p3_out,
  input wire logic rom_disable_in,
  output logic use_ext_rom,
  input wire logic [1:0] cmp_result,
  output logic cmp_power,
  input wire logic timer_eight_bit,
  input wire logic timer_sixteen_bit,
  input wire logic andor_out,
  output logic timer_edge_in,
  output logic ext_int_req_0,
  output logic ext_int_req_1,
  output logic ext_int_req_2,
  output logic [2:0] stop_recovery_select
);
  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int NS = 32;
  logic [NS-1:0] raw; // all asynchronous pins
  logic [NS-1:0] s1; // first stage, read only by s2
  logic [NS-1:0] s2; // synchronised pins
  assign raw = {cmp_result, rom_disable_in, p3_in, p2_in, p1_in, p0_in, 2'h0};
  // two flops on every pin input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 32'h20000000; // rom-disable pin idles high
      s2 <= 32'h20000000;
    end else if (ce) begin
      s1 <= raw;
      s2 <= s1;
    end
  end
  logic [7:0] p0_s; // port 0 pins
  logic [7:0] p1_s; // port 1 pins
  logic [7:0] p2_s; // port 2 pins
  logic [3:1] p3_s; // P31..P33
  logic rdis_s; // rom-disable pin
  logic [1:0] cmp_s; // comparator results
  assign p0_s = s2[9:2];
  assign p1_s = s2[17:10];
  assign p2_s = s2[25:18];
  assign p3_s = s2[28:26];
  assign rdis_s = s2[29];
  assign cmp_s = s2[31:30];
  logic [3:1] p3_d; // previous P31..P33 for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p3_d <= 3'h0;
    end else if (ce) begin
      p3_d <= p3_s;
    end
  end

  ////////////////////////////////////////////////////////////////
  // register file
  logic [12:0] cfg; // port configuration
  logic [1:0] edge_sel; // P31/P32 edge mode
  logic [7:0] p2_dir; // 1 = input
  logic [16:0] tmr; // timer routing bits
  logic [7:0] p0_lat; // port 0 output latch
  logic [7:0] p2_lat; // port 2 output latch
  logic [7:4] p3_lat; // port 3 output latch
  logic wr; // write takes effect
  logic rd; // read data captured, the cycle before ready
  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && penable && !pwrite && !pready;
  logic analog; // port 3 analog mode
  logic stop_md; // stop mode entered
  assign analog = cfg[ioppf_pkg::B_ANALOG];
  assign stop_md = cfg[ioppf_pkg::B_STOP];
  // software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= ioppf_pkg::CFG_RST;
      edge_sel <= ioppf_pkg::EDGE_FALL;
      p2_dir <= 8'hff;
      tmr <= ioppf_pkg::TMR_RST;
      p0_lat <= 8'h00;
      p2_lat <= 8'h00;
      p3_lat <= 4'h0;
    end else if (ce && wr) begin
      case (paddr)
        ioppf_pkg::A_CFG: cfg <= pwdata[ioppf_pkg::CFG_W-1:0]; // R23 R4
        ioppf_pkg::A_EDGE: edge_sel <= pwdata[ioppf_pkg::E_LO+:2]; // R11
        ioppf_pkg::A_P2DIR: p2_dir <= pwdata[7:0]; // R9
        ioppf_pkg::A_TMR: tmr <= pwdata[16:0]; // R14
        ioppf_pkg::A_P0: p0_lat <= pwdata[7:0];
        ioppf_pkg::A_P2: p2_lat <= pwdata[7:0];
        ioppf_pkg::A_P3: p3_lat <= pwdata[7:4];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // handshakes
  logic p0_full; // port 0 byte latched, not yet read
  logic [7:0] p0_hold; // handshake-captured port 0 byte
  logic p2_full; // port 2 byte latched (input role)
  logic [7:0] p2_hold; // captured port 2 byte
  logic p2_dav_out; // port 2 output data valid (output role)
  logic p32_fall; // P32 data-available falling
  logic p31_fall; // P31 falling
  logic p31_rise; // P31 rising
  logic p2_in_role; // port 2 bit 7 is input
  assign p32_fall = p3_d[2] && !p3_s[2];
  assign p31_fall = p3_d[1] && !p3_s[1];
  assign p31_rise = !p3_d[1] && p3_s[1];
  assign p2_in_role = p2_dir[7];
  // input handshake capture; the read releases ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p0_full <= 1'b0;
      p0_hold <= 8'h00;
      p2_full <= 1'b0;
      p2_hold <= 8'h00;
      p2_dav_out <= 1'b0;
    end else if (ce) begin
      if (cfg[ioppf_pkg::B_P0HS] && p32_fall && !p0_full) begin // R8
        p0_full <= 1'b1;
        p0_hold <= p0_s;
      end else if (rd && paddr == ioppf_pkg::A_P0) begin
        p0_full <= 1'b0;
      end
      if (cfg[ioppf_pkg::B_P2HS] && p2_in_role && p31_fall && !p2_full) begin // R10
        p2_full <= 1'b1;
        p2_hold <= p2_s;
      end else if (rd && paddr == ioppf_pkg::A_P2) begin
        p2_full <= 1'b0;
      end
      // output role: new data raises valid, ready rising drops it
      if (wr && paddr == ioppf_pkg::A_P2 && !p2_in_role) begin // R10
        p2_dav_out <= 1'b1;
      end else if (p31_rise) begin
        p2_dav_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // external interrupts and timer input
  // edge match for the selectable-edge inputs
  function automatic logic edge_hit(input logic [1:0] m, input logic d, input logic s);
    case (m)
      ioppf_pkg::EDGE_FALL: edge_hit = d && !s;
      ioppf_pkg::EDGE_RISE: edge_hit = !d && s;
      default: edge_hit = d != s;
    endcase
  endfunction : edge_hit
  // one-cycle request pulses to the interrupt controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_int_req_0 <= 1'b0;
      ext_int_req_1 <= 1'b0;
      ext_int_req_2 <= 1'b0;
      timer_edge_in <= 1'b0;
    end else if (ce) begin
      ext_int_req_0 <= edge_hit(edge_sel, p3_d[2], p3_s[2]); // R11 R22
      ext_int_req_2 <= edge_hit(edge_sel, p3_d[1], p3_s[1]); // R11 R22
      ext_int_req_1 <= !analog && p3_d[3] && !p3_s[3]; // R17 R16 R22
      timer_edge_in <= cfg[ioppf_pkg::B_CTSEL] ? p2_s[0] : p3_s[1]; // R12
    end
  end

  ////////////////////////////////////////////////////////////////
  // comparators and stop recovery sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_power <= 1'b0;
      use_ext_rom <= 1'b0;
      stop_recovery_select <= 3'h0;
    end else if (ce) begin
      cmp_power <= analog && !stop_md; // R15 R18
      use_ext_rom <= !rdis_s; // R6
      stop_recovery_select <= analog ? 3'h0 : p3_s; // R19 R16
    end
  end
  logic [1:0] cmp_live; // comparator results while powered
  assign cmp_live = cmp_power ? cmp_s : 2'h0; // R15 R18

  ////////////////////////////////////////////////////////////////
  // external memory machine cycle
  ioppf_pkg::ioppf_mc_e mc; // cycle state
  logic [1:0] mcnt; // strobe width counter
  logic mc_wr; // current cycle writes
  logic mc_dm; // current cycle is data memory
  logic [15:0] mc_addr; // latched address
  logic [7:0] mc_wd; // latched write data
  // cycle sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc <= ioppf_pkg::MC_IDLE;
      mcnt <= 2'h0;
      mc_wr <= 1'b0;
      mc_dm <= 1'b0;
      mc_addr <= 16'h0000;
      mc_wd <= 8'h00;
    end else if (ce) begin
      case (mc)
        ioppf_pkg::MC_IDLE: begin
          if (mem_req) begin
            mc <= ioppf_pkg::MC_AS;
            mc_wr <= mem_write;
            mc_dm <= mem_data_space;
            mc_addr <= mem_addr;
            mc_wd <= mem_wdata;
            mcnt <= 2'(ioppf_pkg::AS_CYC - 1);
          end
        end
        ioppf_pkg::MC_AS: begin
          if (mcnt == 2'h0) begin
            mc <= ioppf_pkg::MC_GAP;
          end else begin
            mcnt <= mcnt - 2'h1;
          end
        end
        ioppf_pkg::MC_GAP: begin
          mc <= ioppf_pkg::MC_DS;
          mcnt <= 2'(ioppf_pkg::DS_CYC - 1);
        end
        ioppf_pkg::MC_DS: begin
          if (mcnt == 2'h0) begin
            mc <= ioppf_pkg::MC_END;
          end else begin
            mcnt <= mcnt - 2'h1;
          end
        end
        default: mc <= ioppf_pkg::MC_IDLE;
      endcase
    end
  end
  // strobes, direction and completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_address_strobe_n <= 1'b1;
      mem_transfer_strobe_n <= 1'b1;
      read_write <= 1'b1;
      strobe_oe_n <= 1'b0;
      mem_done <= 1'b0;
      mem_rdata <= 8'h00;
    end else if (ce) begin
      cycle_address_strobe_n <= !(mc == ioppf_pkg::MC_IDLE && mem_req); // R3
      mem_transfer_strobe_n <= !(mc == ioppf_pkg::MC_GAP
                                 || (mc == ioppf_pkg::MC_DS && mcnt != 2'h0)); // R1
      read_write <= !(mc_wr && mc != ioppf_pkg::MC_IDLE
                      && mc != ioppf_pkg::MC_END) && !(mc == ioppf_pkg::MC_IDLE
                      && mem_req && mem_write); // R5
      strobe_oe_n <= cfg[ioppf_pkg::B_TRI]; // R4
      mem_done <= mc == ioppf_pkg::MC_END;
      if (mc == ioppf_pkg::MC_END && !mc_wr) begin
        mem_rdata <= p1_s; // R2
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // port drivers
  logic busy; // a machine cycle is in progress
  assign busy = mc != ioppf_pkg::MC_IDLE;
  logic [7:0] next_p0o; // port 0 level
  logic [7:0] next_p0e; // port 0 enables (low drives)
  // port 0 by nibble: address, output latch, or input
  always_comb begin
    next_p0o = p0_lat;
    next_p0e = 8'hff;
    if (cfg[ioppf_pkg::B_P0LOA]) begin // R7
      next_p0o[3:0] = mc_addr[11:8];
      next_p0e[3:0] = 4'h0;
    end else if (cfg[ioppf_pkg::B_P0LOO]) begin
      next_p0e[3:0] = 4'h0;
    end
    if (cfg[ioppf_pkg::B_P0HIA]) begin // R7
      next_p0o[7:4] = mc_addr[15:12];
      next_p0e[7:4] = 4'h0;
    end else if (cfg[ioppf_pkg::B_P0HIO]) begin
      next_p0e[7:4] = 4'h0;
    end
    if (cfg[ioppf_pkg::B_TRI]) begin // R4
      next_p0e = 8'hff;
    end
  end
  logic [7:4] next_p3; // port 3 output levels
  // port 3 output selection, comparators first
  always_comb begin
    next_p3 = p3_lat;
    if (cfg[ioppf_pkg::B_CMPOUT]) begin // R20 R21
      next_p3[4] = cmp_live[0];
      next_p3[7] = cmp_live[1];
    end else if (cfg[ioppf_pkg::B_DMEN]) begin // R13
      next_p3[4] = !(busy && mc_dm);
    end else if (tmr[ioppf_pkg::T0_B]) begin // R14
      next_p3[4] = timer_eight_bit;
    end
    if (cfg[ioppf_pkg::B_P0HS]) begin // R8
      next_p3[5] = !p0_full;
    end else if (tmr[ioppf_pkg::T2_B]) begin // R14
      next_p3[5] = timer_sixteen_bit;
    end
    if (cfg[ioppf_pkg::B_P2HS]) begin // R10
      next_p3[6] = p2_in_role ? !p2_full : !p2_dav_out;
    end else begin
      case (tmr[ioppf_pkg::T1_LO+:2]) // R14
        ioppf_pkg::P36_T8: next_p3[6] = timer_eight_bit;
        ioppf_pkg::P36_T16: next_p3[6] = timer_sixteen_bit;
        ioppf_pkg::P36_LOGIC: next_p3[6] = andor_out;
        default: next_p3[6] = p3_lat[6];
      endcase
    end
  end
  // registered pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p0_out <= 8'h00;
      p0_oe_n <= 8'hff;
      p1_out <= 8'h00;
      p1_oe_n <= 8'hff;
      p2_out <= 8'h00;
      p2_oe_n <= 8'hff;
      p3_out <= 4'h0;
    end else if (ce) begin
      p0_out <= next_p0o;
      p0_oe_n <= next_p0e;
      p3_out <= next_p3;
      // port 1: address at cycle start, write data after
      p1_out <= (mc == ioppf_pkg::MC_IDLE) ? mem_addr[7:0] : mc_wd;
      p1_oe_n <= {8{cfg[ioppf_pkg::B_TRI] || !((mc == ioppf_pkg::MC_IDLE && mem_req)
                 || (busy && mc_wr))}}; // R4
      p2_out <= p2_lat;
      for (int i = 0; i < 8; i++) begin
        p2_oe_n[i] <= p2_dir[i] || !(cfg[ioppf_pkg::B_P2PP] || !p2_lat[i]); // R9
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // APB read path and completion
  logic [31:0] next_rd; // read mux
  logic hit; // address is mapped
  always_comb begin
    next_rd = 32'h0;
    hit = 1'b1;
    case (paddr)
      ioppf_pkg::A_CFG: next_rd = {19'h0, cfg};
      ioppf_pkg::A_EDGE: next_rd = {24'h0, edge_sel, 6'h0};
      ioppf_pkg::A_P2DIR: next_rd = {24'h0, p2_dir};
      ioppf_pkg::A_TMR: next_rd = {15'h0, tmr};
      ioppf_pkg::A_P0: next_rd = {24'h0, cfg[ioppf_pkg::B_P0HS] ? p0_hold : p0_s};
      ioppf_pkg::A_P2: next_rd = {24'h0, p2_full ? p2_hold : p2_s};
      ioppf_pkg::A_P3: next_rd = {24'h0, p3_lat, analog ? 1'b0 : p3_s[3],
                                  p3_s[2:1], 1'b0}; // R17 R16
      ioppf_pkg::A_STAT: next_rd = {25'h0, p2_dav_out, p2_full, p0_full,
                                    use_ext_rom, cmp_live, cmp_power};
      default: hit = 1'b0;
    endcase
  end
  // one wait state, then ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (ce) begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      if (rd) begin
        prdata <= next_rd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  sequence s_start;
    ce && mc == ioppf_pkg::MC_IDLE && mem_req;
  endsequence
  sequence s_as_pulse;
    !cycle_address_strobe_n ##1 cycle_address_strobe_n;
  endsequence
  a_as_once: assert property (@(posedge pclk) disable iff (!presetn)
    s_start |=> s_as_pulse) else $error("address strobe not pulsed"); // R3
  a_ds_width: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(mem_transfer_strobe_n) |-> !mem_transfer_strobe_n [*2] ##1
    mem_transfer_strobe_n) else $error("data strobe width wrong"); // R1
  a_ds_after_as: assert property (@(posedge pclk) disable iff (!presetn)
    s_start ##1 ce [*2] |=> $fell(mem_transfer_strobe_n))
    else $error("data strobe not after address"); // R1
  a_rw_write: assert property (@(posedge pclk) disable iff (!presetn)
    !read_write |-> busy || $past(busy)) else $error("write level outside cycle"); // R5
  a_tri_strobes: assert property (@(posedge pclk) disable iff (!presetn)
    ce && cfg[ioppf_pkg::B_TRI] |=> strobe_oe_n && (&p1_oe_n) && (&p0_oe_n))
    else $error("bus not floated"); // R4
  a_cmp_stop: assert property (@(posedge pclk) disable iff (!presetn)
    ce && stop_md |=> !cmp_power) else $error("comparator powered in stop"); // R18
  a_p33_analog: assert property (@(posedge pclk) disable iff (!presetn)
    analog && $past(analog) |-> !ext_int_req_1) else $error("P33 request in analog"); // R16
  a_smr_digital: assert property (@(posedge pclk) disable iff (!presetn)
    ce && analog |=> stop_recovery_select == 3'h0)
    else $error("recovery source in analog"); // R19
  a_cmp_route: assert property (@(posedge pclk) disable iff (!presetn)
    ce && cfg[ioppf_pkg::B_CMPOUT] |=> p3_out[7] == $past(cmp_live[1]))
    else $error("comparator not on P37"); // R20 R21
  a_rom_sel: assert property (@(posedge pclk) disable iff (!presetn)
    ce ##1 ce |-> use_ext_rom == !$past(rdis_s)) else $error("rom select wrong"); // R6
endmodule : ioppf_top
`default_nettype wire

//--- hw/ioppf_pkg.sv
/*
 Constants for the I/O port pin-function block: register map,
 field positions, reset values, strobe timing and state codes.
 Assumes a 20 MHz APB clock and byte-wide external memory.
*/
// Function
// R1: one low data strobe per memory access
// R2: memory drives read data before strobe rises
// R3: address strobe pulses at each cycle start
// R4: software floats strobes, ports 0 and 1
// R5: read/write low only during external writes
// R6: grounded rom-disable pin forces external fetch
// R7: port 0 push-pull, nibbles I/O or address
// R8: port 0 handshake uses P32 and P35
// R9: port 2 per-bit direction, global drive mode
// R10: port 2 handshake roles follow bit 7
// R11: P31/P32 interrupts select rising/falling/both edges
// R12: timer edge input from P31 or P20
// R13: port 3 carries handshakes, interrupts, memory select
// R14: timer and logic outputs routed by timer controls
// R15: analog mode feeds comparators from P31, P32
// R16: analog mode diverts P33 latch and interrupt
// R17: digital P33 is input bit 3, raises interrupt
// R18: stop mode powers both comparators down
// R19: P31-P33 recover stop only in digital mode
// R20: comparator outputs routable to P34, P37
// R21: config bit 0 selects comparator or plain I/O
// R22: P33 interrupt falls; P31, P32 both edges (code: P31, P32 use the edge_sel mode, falling at reset)
// R23: config bit selects analog or digital port 3
`default_nettype none
package ioppf_pkg;
  // register byte offsets
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_EDGE = 8'h04;
  localparam logic [7:0] A_P2DIR = 8'h08;
  localparam logic [7:0] A_TMR = 8'h0c;
  localparam logic [7:0] A_P0 = 8'h10;
  localparam logic [7:0] A_P2 = 8'h14;
  localparam logic [7:0] A_P3 = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1c;
  // configuration register fields
  localparam int B_CMPOUT = 0;
  localparam int B_ANALOG = 1;
  localparam int B_TRI = 2;
  localparam int B_P0HS = 3;
  localparam int B_P2HS = 4;
  localparam int B_P0LOA = 5;
  localparam int B_P0HIA = 6;
  localparam int B_P2PP = 7;
  localparam int B_CTSEL = 8;
  localparam int B_STOP = 9;
  localparam int B_DMEN = 10;
  localparam int B_P0LOO = 11;
  localparam int B_P0HIO = 12;
  localparam int CFG_W = 13;
  localparam logic [12:0] CFG_RST = 13'h0000;
  // edge register: bits 7:6 pick the P31/P32 edge
  localparam int E_LO = 6;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  // timer routing fields
  localparam int T0_B = 0;
  localparam int T1_LO = 12;
  localparam int T2_B = 16;
  localparam logic [16:0] TMR_RST = 17'h00000;
  localparam logic [1:0] P36_T8 = 2'h1;
  localparam logic [1:0] P36_T16 = 2'h2;
  localparam logic [1:0] P36_LOGIC = 2'h3;
  // strobe timing
  localparam int CLK_MHZ = 20;
  localparam int AS_NS = 50;
  localparam int DS_NS = 100;
  localparam int AS_CYC = (AS_NS * CLK_MHZ + 999) / 1000;
  localparam int DS_CYC = (DS_NS * CLK_MHZ + 999) / 1000;
  // machine cycle states
  typedef enum logic [2:0] {
    MC_IDLE = 3'b000,
    MC_AS = 3'b001,
    MC_GAP = 3'b010,
    MC_DS = 3'b011,
    MC_END = 3'b100
  } ioppf_mc_e;
endpackage : ioppf_pkg
`default_nettype wire

//--- tb/ioppf_mem_model.sv
/*
 external byte memory on port 1, decoding the cycle and transfer strobes.
 assumes the low address byte on port 1 while the address strobe is low.
*/
`default_nettype none
module ioppf_mem_model (
  input wire logic pclk,
  input wire logic as_n,
  input wire logic ds_n,
  input wire logic rw,
  input wire logic [7:0] bus_out,
  input wire logic [7:0] bus_oe_n,
  output logic [7:0] bus_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:255]; // storage, indexed by the low address byte
  logic [7:0] adr = 8'h00; // address latched at the strobe's trailing edge
  logic [7:0] last = 8'h00; // last level put on the bus
  logic [7:0] drv; // level this model offers to the bus
  // address is taken at a clock edge while the address strobe is low
  always @(posedge pclk) if (as_n === 1'b0) adr <= bus_out;
  // write data is taken as the transfer strobe rises
  always @(posedge ds_n) if (rw === 1'b0) mem[adr] <= bus_out;
  // read data stands from strobe fall to strobe rise, a toggling pattern otherwise
  always_comb drv = (ds_n === 1'b0 && rw === 1'b1) ? mem[adr] : ~last;
  always @(posedge pclk) last <= drv;
  // wire level: the device wins where it drives
  assign bus_in = (bus_out & ~bus_oe_n) | (drv & bus_oe_n);
endmodule : ioppf_mem_model
`default_nettype wire

//--- tb/testbench.sv
/*
 apb and pin scenarios for the pin-function block, with external memory.
 assumes a 20 MHz pclk and pin paths settling within six edges.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic mem_req = 1'b0;
  logic mem_write = 1'b0;
  logic mem_data_space = 1'b0;
  logic [15:0] mem_addr = 16'h0000;
  logic [7:0] mem_wdata = 8'h00;
  logic [7:0] p0_in = 8'h00;
  logic [7:0] p2_in = 8'h00;
  logic [3:1] p3_in = 3'h0;
  logic rom_disable_in = 1'b1;
  logic [1:0] cmp_result = 2'h0;
  logic timer_eight_bit = 1'b0;
  logic timer_sixteen_bit = 1'b0;
  logic andor_out = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, mem_done, use_ext_rom, cmp_power, timer_edge_in;
  logic cycle_address_strobe_n, mem_transfer_strobe_n, read_write, strobe_oe_n;
  logic ext_int_req_0, ext_int_req_1, ext_int_req_2;
  logic [7:0] mem_rdata, p0_out, p0_oe_n, p1_out, p1_oe_n, p1_in, p2_out, p2_oe_n;
  logic [7:4] p3_out;
  logic [2:0] stop_recovery_select;
  logic [31:0] rdv; // read data of the last apb access
  logic errv; // error flag of the last apb access
  logic ds_prev = 1'b1; // transfer strobe one edge ago
  int cnt [0:6] = '{default: 0}; // as low, ds low, ds falls, rw low in ds, req0..2
  int base [0:6]; // snapshot of cnt
  int error_cnt = 0;
  int cmp_count = 0;
  int m;
  ioppf_top i_ioppf_top (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mem_req, .mem_write, .mem_data_space, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_done, .cycle_address_strobe_n, .mem_transfer_strobe_n,
    .read_write, .strobe_oe_n, .p0_in, .p0_out, .p0_oe_n, .p1_in, .p1_out, .p1_oe_n,
    .p2_in, .p2_out, .p2_oe_n, .p3_in, .p3_out, .rom_disable_in, .use_ext_rom,
    .cmp_result, .cmp_power, .timer_eight_bit, .timer_sixteen_bit, .andor_out,
    .timer_edge_in, .ext_int_req_0, .ext_int_req_1, .ext_int_req_2, .stop_recovery_select);
  ioppf_mem_model i_ioppf_mem_model (.pclk, .as_n(cycle_address_strobe_n),
    .ds_n(mem_transfer_strobe_n), .rw(read_write), .bus_out(p1_out), .bus_oe_n(p1_oe_n),
    .bus_in(p1_in));
  // clock, 50 ns period
  always #25 pclk = ~pclk;
  // strobe and interrupt monitors, sampled at each rising edge
  always @(posedge pclk) begin
    ds_prev <= mem_transfer_strobe_n;
    cnt[0] <= cnt[0] + int'(cycle_address_strobe_n === 1'b0);
    cnt[1] <= cnt[1] + int'(mem_transfer_strobe_n === 1'b0);
    cnt[2] <= cnt[2] + int'(mem_transfer_strobe_n === 1'b0 && ds_prev === 1'b1);
    cnt[3] <= cnt[3] + int'(mem_transfer_strobe_n === 1'b0 && read_write === 1'b0);
    cnt[4] <= cnt[4] + int'(ext_int_req_0 === 1'b1);
    cnt[5] <= cnt[5] + int'(ext_int_req_1 === 1'b1);
    cnt[6] <= cnt[6] + int'(ext_int_req_2 === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one external memory cycle from the core side
  task automatic mem(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    mem_req <= 1'b1;
    mem_write <= w;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge pclk);
    mem_req <= 1'b0;
    while (mem_done !== 1'b1) @(posedge pclk);
  endtask : mem
  task automatic wrap_up;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // watchdog against a hung handshake
  initial begin
    #1000000;
    error_cnt++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk({cycle_address_strobe_n, mem_transfer_strobe_n, read_write, strobe_oe_n}, 4'he);
    chk({p0_oe_n, p1_oe_n, p2_oe_n}, 24'hffffff);
    apb(0, ioppf_pkg::A_P2DIR, 0);
    chk(rdv, 32'hff);
    apb(0, 8'h20, 0);
    chk({errv, rdv[30:0]}, 32'h80000000);
    // writes then reads through the memory model
    apb(1, ioppf_pkg::A_CFG, 32'h60);
    base = cnt;
    mem(1, 16'hc355, 8'ha5);
    mem(1, 16'h0056, 8'h3c);
    mem(0, 16'h0055, 8'h00);
    chk(mem_rdata, 8'ha5);
    mem(0, 16'hc356, 8'h00);
    chk(mem_rdata, 8'h3c);
    chk(p0_out, 8'hc3);
    chk(cnt[0] - base[0], 4 * ioppf_pkg::AS_CYC);
    chk(cnt[1] - base[1], 4 * ioppf_pkg::DS_CYC);
    chk(cnt[2] - base[2], 4);
    chk(cnt[3] - base[3], 2 * ioppf_pkg::DS_CYC);
    // software float of strobes and port 1
    apb(1, ioppf_pkg::A_CFG, 32'h1 << ioppf_pkg::B_TRI);
    repeat (3) @(posedge pclk);
    chk({strobe_oe_n, p1_oe_n}, 9'h1ff);
    // port 0 low nibble output, port 2 upper nibble output
    apb(1, ioppf_pkg::A_CFG, 32'h1 << ioppf_pkg::B_P0LOO);
    apb(1, ioppf_pkg::A_P2DIR, 32'h0f);
    repeat (3) @(posedge pclk);
    chk({p0_oe_n, p2_oe_n}, 16'hf00f);
    // rom-disable pin both ways
    rom_disable_in <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(use_ext_rom, 1'b1);
    rom_disable_in <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(use_ext_rom, 1'b0);
    // analog mode with comparator outputs on P34 and P37
    apb(1, ioppf_pkg::A_CFG, 32'h3);
    p3_in <= 3'h7;
    for (m = 1; m < 3; m++) begin
      cmp_result <= m[1:0];
      repeat (6) @(posedge pclk);
      chk({p3_out[7], p3_out[4]}, m[1:0]);
    end
    chk(cmp_power, 1'b1);
    apb(0, ioppf_pkg::A_STAT, 0);
    chk(rdv[2:1], 2'h2);
    chk(stop_recovery_select, 3'h0);
    apb(0, ioppf_pkg::A_P3, 0);
    chk(rdv[3], 1'b0);
    base = cnt;
    p3_in <= 3'h3;
    repeat (6) @(posedge pclk);
    chk(cnt[5] - base[5], 0);
    apb(1, ioppf_pkg::A_CFG, 32'h3 | (32'h1 << ioppf_pkg::B_STOP));
    repeat (3) @(posedge pclk);
    chk(cmp_power, 1'b0);
    // digital mode: P33 level, falling edge request
    apb(1, ioppf_pkg::A_CFG, 0);
    repeat (6) @(posedge pclk);
    chk(stop_recovery_select, 3'h3);
    apb(0, ioppf_pkg::A_P3, 0);
    chk(rdv[3:1], 3'h3);
    base = cnt;
    p3_in <= 3'h7;
    repeat (6) @(posedge pclk);
    p3_in <= 3'h3;
    repeat (6) @(posedge pclk);
    chk(cnt[5] - base[5], 1);
    // edge modes fall, rise, both on P32 and P31
    for (m = 0; m < 3; m++) begin
      apb(1, ioppf_pkg::A_EDGE, m << ioppf_pkg::E_LO);
      base = cnt;
      p3_in[2:1] <= 2'h0;
      repeat (6) @(posedge pclk);
      chk(cnt[4] - base[4], int'(m != 1));
      p3_in[2:1] <= 2'h3;
      repeat (6) @(posedge pclk);
      chk(cnt[4] - base[4], (m == 2) ? 2 : 1);
      chk(cnt[6] - base[6], (m == 2) ? 2 : 1);
    end
    // timer edge source P20 then P31
    apb(1, ioppf_pkg::A_CFG, 32'h1 << ioppf_pkg::B_CTSEL);
    p2_in <= 8'h01;
    p3_in[1] <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(timer_edge_in, 1'b1);
    apb(1, ioppf_pkg::A_CFG, 0);
    repeat (6) @(posedge pclk);
    chk(timer_edge_in, 1'b0);
    // timer outputs onto P34 and P36
    apb(1, ioppf_pkg::A_TMR, 32'h1 | (ioppf_pkg::P36_T8 << ioppf_pkg::T1_LO));
    for (m = 1; m >= 0; m--) begin
      timer_eight_bit <= m[0];
      repeat (4) @(posedge pclk);
      chk({p3_out[6], p3_out[4]}, {m[0], m[0]});
    end
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
